// [core/cmp_array.sv]
// Purpose: Four-channel output-compare array with its timebase and APB registers
// Assumes: APB3 slave, zero wait states, 32-bit data
// Notes:   Pin enables drop while DAC or external memory own the pins
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
// Overview of operation
// RL1: Action code 111 in capture setting captures on comparator B event.
// RL2: Compare action code: none, set, clear, toggle, inverting or non-inverting PWM.
// RL3: Control window reaches only the channel chosen by the index register.
// RL4: Comparator A event kind is chosen by its own select field outside.
// RL5: Edge or center PWM shape follows timer count mode, not action code; here PWM is edge-aligned only and count mode is unused.
// RL6: Channel compares when its compare-select bit is one, else captures.
// RL7: Compare event when channel data equals the 16-bit timer count.
// RL8: Each compare event sets that channel's match flag.
// RL9: Clear-timer-on-match bit makes a compare event reset the count to zero.
// RL10: Four compare pins, channels A to D on port 2 bits 0 to 3.
// RL11: Pin action happens even with the channel interrupt disabled.
// RL12: Software sets pin output mode before the first compare event.
// RL13: All compare outputs are one after reset.
// RL14: DAC enabled stops channels C and D driving pins; flags stay.
// RL15: External memory on port 2 stops all channels driving pins.
// RL16: Software rewrites compare values in time for several events per period.
// RL17: Normal mode period follows the reload TOP value.
// RL18: Clear-timer-on-match makes the timer restart after every match.
// RL19: In that mode the compare value sets the interval between events.
// RL20: Capture timer setting recommended with clear-on-match for full range.
// RL21: Reserved codes 110 and 111 leave the pin alone but set the flag.
module cmp_array #(
  parameter int unsigned NUM_CH = cmp_array_pkg::NUM_CH
) (
  input  wire logic              i_clk,
  input  wire logic              i_srst,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [7:0]        i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  input  wire logic              i_cmp_a_event,
  input  wire logic              i_cmp_b_event,
  output logic      [NUM_CH-1:0] o_pin_out,
  output logic      [NUM_CH-1:0] o_pin_oe,
  output logic      [NUM_CH-1:0] o_match_pulse,
  output logic      [NUM_CH-1:0] o_capture_pulse,
  output logic      [NUM_CH-1:0] o_irq_request
);
  // Address decode, shared by write and read paths
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == cmp_array_pkg::OFF_INDEX)  || (a == cmp_array_pkg::OFF_WINDOW) ||
             (a == cmp_array_pkg::OFF_FLAGS)  || (a == cmp_array_pkg::OFF_DATA)   ||
             (a == cmp_array_pkg::OFF_TIMER)  || (a == cmp_array_pkg::OFF_RELOAD) ||
             (a == cmp_array_pkg::OFF_TCTRL)  || (a == cmp_array_pkg::OFF_OUTS);
  endfunction

  logic [1:0]        channel_index_select;
  logic [7:0]        channel_control_register [NUM_CH];
  logic [15:0]       data_reg [NUM_CH];
  logic [NUM_CH-1:0] channel_match_flag;
  logic [15:0]       reload_value;
  logic [5:0]        timer_ctrl;
  logic [1:0]        next_index;
  logic [7:0]        next_ctrl [NUM_CH];
  logic [15:0]       next_data [NUM_CH];
  logic [NUM_CH-1:0] next_flags;
  logic [15:0]       next_reload;
  logic [5:0]        next_tctrl;
  logic [31:0]       next_prdata;
  logic              next_pslverr;
  logic              access;
  logic              setup;
  logic              wr;
  logic [15:0]       count;
  logic              bottom;
  logic [NUM_CH-1:0] match;
  logic [NUM_CH-1:0] capture;
  logic [NUM_CH-1:0] chan_out;
  logic [NUM_CH-1:0] ctc_hit;
  logic [NUM_CH-1:0] pin_allow;
  logic              dac_on;
  logic              extmem_on;

  assign access    = i_psel && i_penable;
  assign setup     = i_psel && !i_penable;
  assign wr        = access && i_pwrite && mapped(i_paddr);
  assign dac_on    = timer_ctrl[cmp_array_pkg::TC_DAC];
  assign extmem_on = timer_ctrl[cmp_array_pkg::TC_EXTMEM];

  // Period comes from the reload value in auto-reload, normal count mode
  cmp_timer u_timer (
    .i_clk                   (i_clk),
    .i_srst                  (i_srst),
    .i_run                   (timer_ctrl[cmp_array_pkg::TC_RUN]),
    .i_capture_reload_select (timer_ctrl[cmp_array_pkg::TC_CPRL]),
    .i_reload                (reload_value), // RL17
    .i_clear                 (|ctc_hit), // RL9 RL18
    .i_load                  (wr && (i_paddr == cmp_array_pkg::OFF_TIMER)),
    .i_load_value            (i_pwdata[15:0]),
    .o_count                 (count),
    .o_bottom                (bottom)
  );

  // One compare unit per channel
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    cmp_channel u_ch (
      .i_clk         (i_clk),
      .i_srst        (i_srst),
      .i_count       (count),
      .i_data        (data_reg[g]), // RL19
      .i_ctrl        (channel_control_register[g]),
      .i_bottom      (bottom),
      .i_cmp_a_event (i_cmp_a_event),
      .i_cmp_b_event (i_cmp_b_event),
      .o_match       (match[g]),
      .o_capture     (capture[g]),
      .o_out         (chan_out[g])
    );
    assign ctc_hit[g] = match[g] && channel_control_register[g][cmp_array_pkg::CC_CTC];
    // Pins C and D go to the DAC; all four lose the pin to external memory
    assign pin_allow[g] = !extmem_on && !(dac_on && (g >= 2)); // RL14 RL15
  end

  // Register writes; window and data follow the index
  always_comb begin
    next_index  = channel_index_select;
    next_flags  = channel_match_flag | match; // RL8
    next_reload = reload_value;
    next_tctrl  = timer_ctrl;
    for (int c = 0; c < NUM_CH; c++) begin
      next_ctrl[c] = channel_control_register[c];
      next_data[c] = data_reg[c];
    end
    if (wr) begin
      unique case (i_paddr)
        cmp_array_pkg::OFF_INDEX:  next_index = i_pwdata[1:0];
        cmp_array_pkg::OFF_WINDOW: next_ctrl[channel_index_select] = i_pwdata[7:0]; // RL3
        // Set wins over write-one-to-clear in the same cycle
        cmp_array_pkg::OFF_FLAGS:  next_flags = (channel_match_flag & ~i_pwdata[NUM_CH-1:0]) | match;
        cmp_array_pkg::OFF_DATA:   next_data[channel_index_select] = i_pwdata[15:0];
        cmp_array_pkg::OFF_RELOAD: next_reload = i_pwdata[15:0];
        cmp_array_pkg::OFF_TCTRL:  next_tctrl = i_pwdata[5:0];
        default: next_index = channel_index_select;
      endcase
    end
  end

  // Read mux decoded in setup so data and error stand beside ready in access
  always_comb begin
    next_prdata  = 32'h00000000;
    next_pslverr = 1'b0;
    if (setup && !i_pwrite) begin
      unique case (i_paddr)
        cmp_array_pkg::OFF_INDEX:  next_prdata = {30'h0, channel_index_select};
        cmp_array_pkg::OFF_WINDOW: next_prdata = {24'h0, channel_control_register[channel_index_select]}; // RL3
        cmp_array_pkg::OFF_FLAGS:  next_prdata = {{(32-NUM_CH){1'b0}}, channel_match_flag};
        cmp_array_pkg::OFF_DATA:   next_prdata = {16'h0, data_reg[channel_index_select]};
        cmp_array_pkg::OFF_TIMER:  next_prdata = {16'h0, count};
        cmp_array_pkg::OFF_RELOAD: next_prdata = {16'h0, reload_value};
        cmp_array_pkg::OFF_TCTRL:  next_prdata = {26'h0, timer_ctrl};
        cmp_array_pkg::OFF_OUTS:   next_prdata = {{(32-NUM_CH){1'b0}}, chan_out};
        default:                   next_pslverr = 1'b1;
      endcase
    end else if (setup && !mapped(i_paddr)) begin
      next_pslverr = 1'b1;
    end
  end

  // State registers and registered outputs
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      channel_index_select <= 2'h0;
      channel_match_flag   <= '0;
      reload_value         <= cmp_array_pkg::RELOAD_RESET;
      timer_ctrl           <= cmp_array_pkg::TCTRL_RESET;
      for (int c = 0; c < NUM_CH; c++) begin
        channel_control_register[c] <= cmp_array_pkg::CC_RESET;
        data_reg[c]                 <= 16'h0000;
      end
      o_prdata        <= 32'h00000000;
      o_pready        <= 1'b0;
      o_pslverr       <= 1'b0;
      o_pin_out       <= '1; // RL13
      o_pin_oe        <= '0;
      o_match_pulse   <= '0;
      o_capture_pulse <= '0;
      o_irq_request   <= '0;
    end else begin
      channel_index_select <= next_index;
      channel_match_flag   <= next_flags;
      reload_value         <= next_reload;
      timer_ctrl           <= next_tctrl;
      for (int c = 0; c < NUM_CH; c++) begin
        channel_control_register[c] <= next_ctrl[c];
        data_reg[c]                 <= next_data[c];
        o_irq_request[c] <= next_flags[c] && next_ctrl[c][cmp_array_pkg::CC_IEN];
      end
      o_prdata        <= next_prdata;
      o_pready        <= i_psel && !i_penable;
      o_pslverr       <= next_pslverr;
      o_pin_out       <= chan_out; // RL10
      o_pin_oe        <= pin_allow; // RL14 RL15
      o_match_pulse   <= match;
      o_capture_pulse <= capture;
    end
  end
endmodule // cmp_array

// [core/cmp_array_pkg.sv]
// Purpose: Shared constants for the four-channel output-compare array
// Assumes: 32-bit APB register access, one word per register
// Notes:   Offsets are byte addresses
package cmp_array_pkg;
  localparam int unsigned NUM_CH = 4;
  // Register byte offsets
  localparam logic [7:0] OFF_INDEX   = 8'h00; // channel_index_select
  localparam logic [7:0] OFF_WINDOW  = 8'h04; // channel_control_window
  localparam logic [7:0] OFF_FLAGS   = 8'h08; // channel_flag_register, write 1 to clear
  localparam logic [7:0] OFF_DATA    = 8'h0c; // compare data of selected channel
  localparam logic [7:0] OFF_TIMER   = 8'h10; // timer count {high, low}
  localparam logic [7:0] OFF_RELOAD  = 8'h14; // reload value {high, low}
  localparam logic [7:0] OFF_TCTRL   = 8'h18; // run, capture_reload_select, count mode, misc
  localparam logic [7:0] OFF_OUTS    = 8'h1c; // compare output states
  // Channel control field positions
  localparam int unsigned CC_ACT_LSB = 0;
  localparam int unsigned CC_CSEL    = 3;
  localparam int unsigned CC_CTC     = 4;
  localparam int unsigned CC_IEN     = 7;
  // Timer control field positions
  localparam int unsigned TC_RUN     = 0;
  localparam int unsigned TC_CPRL    = 1;
  localparam int unsigned TC_MODE_LSB = 2;
  localparam int unsigned TC_DAC     = 4;
  localparam int unsigned TC_EXTMEM  = 5;
  // Reset values
  localparam logic [7:0]  CC_RESET    = 8'h00;
  localparam logic [15:0] TIMER_RESET = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'hffff;
  localparam logic [5:0]  TCTRL_RESET = 6'h00;
  localparam logic [1:0]  MODE_NORMAL = 2'h1;
  // Channel action codes
  typedef enum logic [2:0] {
    ACT_NONE   = 3'h0,
    ACT_SET    = 3'h1,
    ACT_CLEAR  = 3'h2,
    ACT_TOGGLE = 3'h3,
    ACT_PWM_INV = 3'h4,
    ACT_PWM_NONINV = 3'h5,
    ACT_RSVD6  = 3'h6,
    ACT_RSVD7  = 3'h7
  } action_e;
endpackage

// [core/cmp_channel.sv]
// Purpose: One compare channel: match detect and pin action
// Assumes: Count and data are both 16 bits
// Notes:   PWM here is edge-aligned only; symmetric count modes are not built
`timescale 1ns/10ps
module cmp_channel (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic [15:0] i_count,
  input  wire logic [15:0] i_data,
  input  wire logic [7:0]  i_ctrl,
  input  wire logic        i_bottom,
  input  wire logic        i_cmp_a_event,
  input  wire logic        i_cmp_b_event,
  output logic             o_match,
  output logic             o_capture,
  output logic             o_out
);
  logic [2:0] code;
  logic       csel;
  logic       next_out;

  assign code = i_ctrl[cmp_array_pkg::CC_ACT_LSB +: 3];
  assign csel = i_ctrl[cmp_array_pkg::CC_CSEL];
  // Compare mode when select bit is one, capture otherwise
  assign o_match = csel && (i_count == i_data); // RL6 RL7
  // Comparator events picked by their own select fields outside
  assign o_capture = !csel && ((code == 3'h6 && i_cmp_a_event) || (code == 3'h7 && i_cmp_b_event)); // RL1 RL4

  // Pin action on match, independent of interrupt enable
  always_comb begin
    next_out = o_out;
    if (csel) begin
      unique case (cmp_array_pkg::action_e'(code)) // RL2
        cmp_array_pkg::ACT_NONE: next_out = o_out;
        cmp_array_pkg::ACT_SET: if (o_match) next_out = 1'b1; // RL11
        cmp_array_pkg::ACT_CLEAR: if (o_match) next_out = 1'b0;
        cmp_array_pkg::ACT_TOGGLE: if (o_match) next_out = !o_out;
        // Polarity per code; shape is edge-aligned only, count mode is not used
        cmp_array_pkg::ACT_PWM_INV: begin // RL5
          if (i_bottom) next_out = 1'b1;
          else if (o_match) next_out = 1'b0;
        end
        cmp_array_pkg::ACT_PWM_NONINV: begin
          if (i_bottom) next_out = 1'b0;
          else if (o_match) next_out = 1'b1;
        end
        cmp_array_pkg::ACT_RSVD6, cmp_array_pkg::ACT_RSVD7: next_out = o_out; // RL21
      endcase
    end
  end

  // Output state starts high
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_out <= 1'b1; // RL13
    end else begin
      o_out <= next_out;
    end
  end
endmodule // cmp_channel

// [core/cmp_timer.sv]
// Purpose: 16-bit up counter serving as the compare timebase
// Assumes: Counts every clock while run is set
// Notes:   Auto-reload wraps at the reload value; capture mode wraps at ffff
`timescale 1ns/10ps
module cmp_timer (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_run,
  input  wire logic        i_capture_reload_select,
  input  wire logic [15:0] i_reload,
  input  wire logic        i_clear,
  input  wire logic        i_load,
  input  wire logic [15:0] i_load_value,
  output logic      [15:0] o_count,
  output logic             o_bottom
);
  logic [15:0] next_count;
  logic        wrap;

  // Top of count: reload value sets the period in auto-reload mode
  always_comb begin
    wrap       = (!i_capture_reload_select) && (o_count == i_reload);
    next_count = o_count;
    if (i_load) begin
      next_count = i_load_value;
    end else if (i_clear) begin
      next_count = cmp_array_pkg::TIMER_RESET;
    end else if (i_run) begin
      next_count = wrap ? cmp_array_pkg::TIMER_RESET : 16'(o_count + 16'h0001);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_count  <= cmp_array_pkg::TIMER_RESET;
      o_bottom <= 1'b0;
    end else begin
      o_count  <= next_count;
      o_bottom <= i_run && !i_load && !i_clear && wrap;
    end
  end
endmodule // cmp_timer

// [tb/cmp_array_assertions.sv]
// Purpose: Port-level checks of the compare array
// Assumes: Zero-wait APB, registered outputs
// Notes:   Timer control is shadowed from bus writes
`timescale 1ns/10ps
module cmp_array_assertions #(
  parameter int unsigned NUM_CH = 4
) (
  input wire logic              i_clk,
  input wire logic              i_srst,
  input wire logic              i_psel,
  input wire logic              i_penable,
  input wire logic              i_pwrite,
  input wire logic [7:0]        i_paddr,
  input wire logic [31:0]       i_pwdata,
  input wire logic [31:0]       o_prdata,
  input wire logic              o_pready,
  input wire logic              o_pslverr,
  input wire logic              i_cmp_a_event,
  input wire logic              i_cmp_b_event,
  input wire logic [NUM_CH-1:0] o_pin_out,
  input wire logic [NUM_CH-1:0] o_pin_oe,
  input wire logic [NUM_CH-1:0] o_match_pulse,
  input wire logic [NUM_CH-1:0] o_capture_pulse,
  input wire logic [NUM_CH-1:0] o_irq_request
);
  logic [5:0] sh_tc;
  logic [5:0] next_sh_tc;
  logic       ext;
  logic       dac;
  // Shadow updates on the same edge as the design's own write
  always_comb begin
    next_sh_tc = sh_tc;
    if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == cmp_array_pkg::OFF_TCTRL)
      next_sh_tc = i_pwdata[5:0];
  end
  always_ff @(posedge i_clk) begin
    sh_tc <= i_srst ? 6'h00 : next_sh_tc;
  end
  assign ext = sh_tc[cmp_array_pkg::TC_EXTMEM];
  assign dac = sh_tc[cmp_array_pkg::TC_DAC];
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  AST_RESET_STATE: assert property ($fell(i_srst) |-> o_pin_out == '1 && o_pin_oe == '0 && !o_pready)
    else $error("outputs not at reset state");
  AST_SETUP_ANSWER: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  AST_READY_ONE: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  AST_READY_CAUSE: assert property (o_pready |-> $past(i_psel && !i_penable))
    else $error("ready without setup");
  AST_NO_ERROR: assert property (o_pready && i_paddr[7:5] == 3'h0 && i_paddr[1:0] == 2'h0 |-> !o_pslverr)
    else $error("slave error on a mapped register");
  AST_ERROR_UNMAPPED: assert property (o_pready && !(i_paddr[7:5] == 3'h0 && i_paddr[1:0] == 2'h0) |-> o_pslverr)
    else $error("no slave error on an unmapped address");
  AST_EXTMEM_OFF: assert property (ext && $past(ext) |-> o_pin_oe == '0)
    else $error("pin driven during external memory use");
  AST_DAC_OFF: assert property (dac && $past(dac) |-> o_pin_oe[NUM_CH-1:2] == '0)
    else $error("upper pins driven with converter on");
  AST_PINS_ON: assert property (!ext && !dac && $past(!ext && !dac) && !$past(i_srst) |-> o_pin_oe == '1)
    else $error("pin not driven");
  cover property (o_match_pulse[0]);
  cover property (o_capture_pulse != '0);
  cover property (ext && o_pin_oe == '0);
  cover property (o_pready && !i_pwrite);
endmodule // cmp_array_assertions
bind cmp_array cmp_array_assertions #(.NUM_CH(NUM_CH)) u_chk (.*);

// [tb/cmp_env_model.sv]
// Purpose: Far side of the compare array: comparator event sources and pads
// Assumes: Pads carry a pull-up while the block does not drive them
// Notes:   Events are one-cycle pulses requested by the bench
`timescale 1ns/10ps
module cmp_env_model (
  input  wire logic       i_clk,
  input  wire logic       i_fire_a,
  input  wire logic       i_fire_b,
  input  wire logic [3:0] i_pin_out,
  input  wire logic [3:0] i_pin_oe,
  output logic            o_cmp_a_event = 1'b0,
  output logic            o_cmp_b_event = 1'b0,
  output logic      [3:0] o_pad
);
  always @(posedge i_clk) begin
    o_cmp_a_event <= i_fire_a;
    o_cmp_b_event <= i_fire_b;
  end
  // Undriven pad floats to the pull-up, never keeps the last level
  always_comb begin
    for (int i = 0; i < 4; i++) o_pad[i] = i_pin_oe[i] ? i_pin_out[i] : 1'b1;
  end
endmodule // cmp_env_model

// [tb/tb.sv]
// Purpose: Register-level tests of the compare array
// Assumes: Read data is taken at the edge that samples ready high
// Notes:   Expected pin patterns worked out per pass
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, fire_a, fire_b, ev_a, ev_b;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pin_out, pin_oe, mpulse, cpulse, irq, pad;
  int          miscompares = 0;
  int          total_checks = 0;
  int          n;
  cmp_array uut (.i_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_cmp_a_event(ev_a), .i_cmp_b_event(ev_b), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
    .o_match_pulse(mpulse), .o_capture_pulse(cpulse), .o_irq_request(irq));
  cmp_env_model env (.i_clk(clk), .i_fire_a(fire_a), .i_fire_b(fire_b), .i_pin_out(pin_out),
    .i_pin_oe(pin_oe), .o_cmp_a_event(ev_a), .o_cmp_b_event(ev_b), .o_pad(pad));
  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // One transfer; request held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Values read here are those sampled at this edge; the watchdog bounds the wait
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    `CHK($sformatf("register %h", a), e, r)
  endtask
  // Control bytes for channels A..D, each read back afterwards
  task automatic set_channels(input logic [31:0] c);
    for (int ch = 0; ch < 4; ch++) begin
      wr(cmp_array_pkg::OFF_INDEX, ch);
      wr(cmp_array_pkg::OFF_WINDOW, c[8*ch+:8]);
    end
    for (int ch = 0; ch < 4; ch++) begin
      wr(cmp_array_pkg::OFF_INDEX, ch);
      rd_chk(cmp_array_pkg::OFF_WINDOW, c[8*ch+:8]);
    end
  endtask
  // Timer runs past every compare point once, then stops well clear of them
  task automatic run_pass(input logic [31:0] c, input logic [3:0] ep, input logic [3:0] ei);
    set_channels(c);
    wr(cmp_array_pkg::OFF_TIMER, 32'h0);
    wr(cmp_array_pkg::OFF_TCTRL, 32'h5);
    repeat (60) @(posedge clk);
    wr(cmp_array_pkg::OFF_TCTRL, 32'h4);
    repeat (3) @(posedge clk) #1;
    `CHK("pins", ep, pin_out)
    `CHK("interrupt requests", ei, irq)
    rd_chk(cmp_array_pkg::OFF_FLAGS, 32'hf);
    wr(cmp_array_pkg::OFF_FLAGS, 32'hf);
    rd_chk(cmp_array_pkg::OFF_FLAGS, 32'h0);
  endtask
  task automatic fire(input logic a, input logic b, input logic [3:0] e);
    logic [3:0] seen;
    seen = '0;
    @(posedge clk);
    fire_a <= a;
    fire_b <= b;
    @(posedge clk);
    fire_a <= 1'b0;
    fire_b <= 1'b0;
    repeat (6) @(posedge clk) #1 seen |= cpulse;
    `CHK("capture pulses", e, seen)
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog well beyond the roughly 1300 cycles the tests need
  initial begin
    #100000;
    miscompares++;
    final_report();
  end
  initial begin
    srst = 1'b1;
    {psel, penable, pwrite, fire_a, fire_b} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    #1 `CHK("pins after reset", 4'hf, pin_out)
    rd_chk(cmp_array_pkg::OFF_OUTS, 32'hf);
    rd_chk(cmp_array_pkg::OFF_RELOAD, 32'hffff);
    for (int ch = 0; ch < 4; ch++) begin
      wr(cmp_array_pkg::OFF_INDEX, ch);
      wr(cmp_array_pkg::OFF_DATA, 32'h20 + ch);
    end
    wr(cmp_array_pkg::OFF_RELOAD, 32'hff);
    // Clear, toggle, none, reserved 6; then set, toggle, clear, reserved 7
    run_pass(32'h0e080b0a, 4'hc, 4'h0);
    run_pass(32'h0f0a0b89, 4'hb, 4'h1);
    // Edge-aligned duty over one 128-cycle period, data 20h
    wr(cmp_array_pkg::OFF_RELOAD, 32'h7f);
    for (int k = 0; k < 2; k++) begin
      set_channels({24'h080808, 8'h0c + k[7:0]});
      wr(cmp_array_pkg::OFF_TIMER, 32'h0);
      wr(cmp_array_pkg::OFF_TCTRL, 32'h5);
      repeat (140) @(posedge clk);
      n = 0;
      repeat (128) @(posedge clk) #1 n += pin_out[0];
      `CHK("pwm high cycles", (k == 0) ? 32 : 96, n)
      wr(cmp_array_pkg::OFF_TCTRL, 32'h4);
    end
    // Compare point moved after the first match gives a second one in the period
    set_channels(32'h0808080b);
    wr(cmp_array_pkg::OFF_INDEX, 32'h0);
    wr(cmp_array_pkg::OFF_DATA, 32'h10);
    wr(cmp_array_pkg::OFF_TIMER, 32'h0);
    wr(cmp_array_pkg::OFF_TCTRL, 32'h5);
    n = 0;
    while (mpulse[0] !== 1'b1 && n < 200) @(posedge clk) #1 n++;
    wr(cmp_array_pkg::OFF_DATA, 32'h40);
    n = 0;
    repeat (80) @(posedge clk) #1 n += mpulse[0];
    `CHK("second match in period", 1, n)
    wr(cmp_array_pkg::OFF_TCTRL, 32'h4);
    wr(cmp_array_pkg::OFF_FLAGS, 32'hf);
    // Clear on match with port given to external memory
    set_channels(32'h0808081b);
    wr(cmp_array_pkg::OFF_INDEX, 32'h0);
    wr(cmp_array_pkg::OFF_DATA, 32'h0f);
    wr(cmp_array_pkg::OFF_TIMER, 32'h0);
    wr(cmp_array_pkg::OFF_TCTRL, 32'h23);
    repeat (3) @(posedge clk) #1;
    `CHK("enables, external memory", 4'h0, pin_oe)
    `CHK("pads, external memory", 4'hf, pad)
    n = 0;
    while (mpulse[0] !== 1'b1 && n < 200) @(posedge clk) #1 n++;
    n = 0;
    do @(posedge clk) #1 n++; while (mpulse[0] !== 1'b1 && n < 200);
    `CHK("match interval", 16, n)
    wr(cmp_array_pkg::OFF_TCTRL, 32'h10);
    rd_chk(cmp_array_pkg::OFF_FLAGS, 32'h1);
    repeat (3) @(posedge clk) #1;
    `CHK("enables, converter on", 4'h3, pin_oe)
    wr(cmp_array_pkg::OFF_TCTRL, 32'h0);
    repeat (3) @(posedge clk) #1;
    `CHK("enables, all free", 4'hf, pin_oe)
    // Capture on comparator events: A by code 110, B by code 111
    set_channels(32'h08080607);
    fire(1'b1, 1'b0, 4'h2);
    fire(1'b0, 1'b1, 4'h1);
    // Unmapped write must leave the index alone
    wr(8'h40, 32'hffffffff);
    rd_chk(cmp_array_pkg::OFF_INDEX, 32'h3);
    final_report();
  end
endmodule // tb
